// File: core/gpio_pkg.sv
/*
  package for the three-port general purpose i/o block: register selects,
  reset values, pin counts and the carrier structs.
  assumes the core presents a simple select/strobe access per register.
*/
package gpio_pkg;
  // ==========================================================
  // geometry
  localparam int PORT_W = 8;
  localparam int NPINS = 17;
  localparam int C_BIT = 0;
  // ==========================================================
  // register selects, local to this block's decode
  localparam logic [3:0] SEL_A_DATA = 4'h0;
  localparam logic [3:0] SEL_A_DIR = 4'h1;
  localparam logic [3:0] SEL_A_PU = 4'h2;
  localparam logic [3:0] SEL_A_WU = 4'h3;
  localparam logic [3:0] SEL_B_DATA = 4'h4;
  localparam logic [3:0] SEL_B_DIR = 4'h5;
  localparam logic [3:0] SEL_B_PU = 4'h6;
  localparam logic [3:0] SEL_B_WU = 4'h7;
  localparam logic [3:0] SEL_C_DATA = 4'h8;
  localparam logic [3:0] SEL_C_DIR = 4'h9;
  localparam logic [3:0] SEL_C_PU = 4'ha;
  localparam logic [3:0] SEL_C_WU = 4'hb;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PU = 8'h00;
  localparam logic [7:0] RST_WU = 8'h00;
  localparam logic [7:0] C_MASK = 8'h01;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic sel;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [NPINS-1:0] data;
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] pu;
    logic [NPINS-1:0] wu;
  } port_regs_t;

  typedef struct packed {
    logic normal_wdt;
    logic halted;
  } sys_state_t;
endpackage : gpio_pkg

// File: core/pin_sync.sv
/*
  two-flop synchroniser for the pin levels.
  assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module pin_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [gpio_pkg::NPINS-1:0] d,
  output logic [gpio_pkg::NPINS-1:0] q
);
  import gpio_pkg::*;
  logic [NPINS-1:0] meta_ff;
  logic [NPINS-1:0] q_ff;
  // ==========================================================
  // synchroniser; reset high matches idle pulled-up pins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '1;
      q_ff <= '1;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule : pin_sync

// File: core/wake_detect.sv
/*
  falling-edge wake detector over all pins.
  assumes synchronised pin levels and a per-pin arm mask already gated by halted in the core.
*/
`timescale 1ns/1ps
module wake_detect (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [gpio_pkg::NPINS-1:0] lvl,
  input wire logic [gpio_pkg::NPINS-1:0] arm,
  output logic wake
);
  import gpio_pkg::*;
  logic [NPINS-1:0] prev_ff;
  logic [NPINS-1:0] fall;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= '1;
    end else begin
      prev_ff <= lvl;
    end
  end
  assign fall = prev_ff & ~lvl & arm;
  assign wake = |fall;
endmodule : wake_detect

// File: core/gpio_ports.sv
/*
  general purpose i/o: port a (8), port b (8), port c (1 pin at bit 0).
  registers reached by a per-register select with read and write strobe
  from the core's data memory decode. assumes a core-side reset type
  indication (power-on via rstn, watchdog via wdt_timeout pulse).
*/
`timescale 1ns/1ps
module gpio_ports (
  input wire logic core_clk,
  input wire logic rstn,
  input wire gpio_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic wdt_timeout,
  input wire gpio_pkg::sys_state_t sys,
  input wire logic [gpio_pkg::NPINS-1:0] pin_in,
  output logic [gpio_pkg::NPINS-1:0] pin_out,
  output logic [gpio_pkg::NPINS-1:0] pin_oe,
  output logic [gpio_pkg::NPINS-1:0] pin_pullup,
  output logic wake_req
);
  import gpio_pkg::*;

  // ==========================================================
  // storage
  logic [7:0] a_data_ff, a_dir_ff, a_pu_ff, a_wu_ff;
  logic [7:0] b_data_ff, b_dir_ff, b_pu_ff, b_wu_ff;
  logic c_data_ff, c_dir_ff, c_pu_ff, c_wu_ff;
  logic [NPINS-1:0] pin_sync_lvl;
  logic [NPINS-1:0] all_data, all_dir, all_pu, all_wu;
  logic [NPINS-1:0] rd_mix;
  logic [NPINS-1:0] wake_arm;
  logic wr_en;
  logic soft_rst;

  assign wr_en = req.sel & req.wr;
  // a halted watchdog time-out is not a port reset at all
  assign soft_rst = wdt_timeout & sys.normal_wdt & ~sys.halted;

  // ==========================================================
  // pin input synchroniser
  pin_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d(pin_in),
    .q(pin_sync_lvl)
  );

  // ==========================================================
  // port a registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      a_data_ff <= RST_DATA;
      a_dir_ff <= RST_DIR;
      a_pu_ff <= RST_PU;
      a_wu_ff <= RST_WU;
    end else if (soft_rst) begin
      a_data_ff <= RST_DATA;
      a_dir_ff <= RST_DIR;
      a_pu_ff <= RST_PU;
      a_wu_ff <= RST_WU;
    end else if (wr_en) begin
      if (req.addr == SEL_A_DATA) a_data_ff <= req.wdata;
      if (req.addr == SEL_A_DIR) a_dir_ff <= req.wdata;
      if (req.addr == SEL_A_PU) a_pu_ff <= req.wdata;
      if (req.addr == SEL_A_WU) a_wu_ff <= req.wdata;
    end
  end

  // ==========================================================
  // port b registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      b_data_ff <= RST_DATA;
      b_dir_ff <= RST_DIR;
      b_pu_ff <= RST_PU;
      b_wu_ff <= RST_WU;
    end else if (soft_rst) begin
      b_data_ff <= RST_DATA;
      b_dir_ff <= RST_DIR;
      b_pu_ff <= RST_PU;
      b_wu_ff <= RST_WU;
    end else if (wr_en) begin
      if (req.addr == SEL_B_DATA) b_data_ff <= req.wdata;
      if (req.addr == SEL_B_DIR) b_dir_ff <= req.wdata;
      if (req.addr == SEL_B_PU) b_pu_ff <= req.wdata;
      if (req.addr == SEL_B_WU) b_wu_ff <= req.wdata;
    end
  end

  // ==========================================================
  // port c registers, bit 0 only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c_data_ff <= RST_DATA[C_BIT];
      c_dir_ff <= RST_DIR[C_BIT];
      c_pu_ff <= RST_PU[C_BIT];
      c_wu_ff <= RST_WU[C_BIT];
    end else if (soft_rst) begin
      c_data_ff <= RST_DATA[C_BIT];
      c_dir_ff <= RST_DIR[C_BIT];
      c_pu_ff <= RST_PU[C_BIT];
      c_wu_ff <= RST_WU[C_BIT];
    end else if (wr_en) begin
      if (req.addr == SEL_C_DATA) c_data_ff <= req.wdata[C_BIT];
      if (req.addr == SEL_C_DIR) c_dir_ff <= req.wdata[C_BIT];
      if (req.addr == SEL_C_PU) c_pu_ff <= req.wdata[C_BIT];
      if (req.addr == SEL_C_WU) c_wu_ff <= req.wdata[C_BIT];
    end
  end

  // ==========================================================
  // flattened pin view: [7:0] a, [15:8] b, [16] c
  assign all_data = {c_data_ff, b_data_ff, a_data_ff};
  assign all_dir = {c_dir_ff, b_dir_ff, a_dir_ff};
  assign all_pu = {c_pu_ff, b_pu_ff, a_pu_ff};
  assign all_wu = {c_wu_ff, b_wu_ff, a_wu_ff};

  // ==========================================================
  // per-pin drive, pull and read mux
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      assign pin_oe[gi] = ~all_dir[gi];
      assign pin_out[gi] = all_data[gi];
      // no nmos mode exists here, so input is the only pulled case
      assign pin_pullup[gi] = all_pu[gi] & all_dir[gi];
      // input reads the live (synchronised) pin, output reads the latch
      assign rd_mix[gi] = all_dir[gi] ? pin_sync_lvl[gi] : all_data[gi];
      assign wake_arm[gi] = all_wu[gi] & all_dir[gi] & sys.halted;
    end
  endgenerate

  // ==========================================================
  // read decode
  logic [7:0] rd_sel;
  always_comb begin
    rd_sel = 8'h00;
    unique case (req.addr)
      SEL_A_DATA: rd_sel = rd_mix[7:0];
      SEL_A_DIR: rd_sel = a_dir_ff;
      SEL_A_PU: rd_sel = a_pu_ff;
      SEL_A_WU: rd_sel = a_wu_ff;
      SEL_B_DATA: rd_sel = rd_mix[15:8];
      SEL_B_DIR: rd_sel = b_dir_ff;
      SEL_B_PU: rd_sel = b_pu_ff;
      SEL_B_WU: rd_sel = b_wu_ff;
      SEL_C_DATA: rd_sel = {7'h00, rd_mix[16]};
      SEL_C_DIR: rd_sel = {7'h00, c_dir_ff};
      SEL_C_PU: rd_sel = {7'h00, c_pu_ff};
      SEL_C_WU: rd_sel = {7'h00, c_wu_ff};
      default: rd_sel = 8'h00;
    endcase
  end
  // combinational read: the level is taken in the read cycle itself
  assign rdata = req.sel ? rd_sel : 8'h00;

  // ==========================================================
  // wake-up
  wake_detect u_wake (
    .core_clk(core_clk),
    .rstn(rstn),
    .lvl(pin_sync_lvl),
    .arm(wake_arm),
    .wake(wake_req)
  );

  // ==========================================================
  // checks
  property p_oe_dir;
    @(posedge core_clk) disable iff (!rstn)
      (pin_oe == ~all_dir);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("oe not inverse of dir");

  property p_pull_out;
    @(posedge core_clk) disable iff (!rstn)
      |(pin_pullup & pin_oe) == 1'b0;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull on driving pin");

  property p_latch_hold;
    @(posedge core_clk) disable iff (!rstn)
      (!wr_en && !soft_rst) |=> $stable(a_data_ff) && $stable(b_data_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved unwritten");

  property p_wr_data;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr == SEL_A_DATA) |=> a_data_ff == $past(req.wdata);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("data write lost");

  property p_soft_rst;
    @(posedge core_clk) disable iff (!rstn)
      soft_rst |=> (all_pu == '0) && (all_wu == '0) && (&all_dir) && (&all_data);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("normal wdt reset wrong");

  property p_halt_keep;
    @(posedge core_clk) disable iff (!rstn)
      (wdt_timeout && sys.halted && !wr_en) |=> $stable(all_pu) && $stable(all_dir);
  endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("halted wdt changed regs");

  property p_wake_gate;
    @(posedge core_clk) disable iff (!rstn)
      !sys.halted |-> !wake_req;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake while running");

  property p_pc_upper;
    @(posedge core_clk) disable iff (!rstn)
      (req.sel && req.addr >= SEL_C_DATA) |-> (rdata & ~C_MASK) == 8'h00;
  endproperty
  a_pc_upper: assert property (p_pc_upper) else $error("port c upper bits nonzero");

  sequence s_high_armed;
    pin_sync_lvl[0] && wake_arm[0];
  endsequence
  property p_wake_fall;
    @(posedge core_clk) disable iff (!rstn)
      s_high_armed ##1 (!pin_sync_lvl[0] && wake_arm[0]) |-> wake_req;
  endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("falling edge missed");

  property p_rd_out;
    @(posedge core_clk) disable iff (!rstn)
      (req.sel && req.addr == SEL_A_DATA && a_dir_ff == 8'h00) |-> rdata == a_data_ff;
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("output read not latch");

  property p_wr_dir;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr == SEL_A_DIR) |=> a_dir_ff == $past(req.wdata);
  endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("direction write lost");

  property p_wr_pu;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr == SEL_A_PU) |=> a_pu_ff == $past(req.wdata);
  endproperty
  a_wr_pu: assert property (p_wr_pu) else $error("pull enable write lost");

  property p_wr_wu;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr == SEL_A_WU) |=> a_wu_ff == $past(req.wdata);
  endproperty
  a_wr_wu: assert property (p_wr_wu) else $error("wake enable write lost");

  property p_wr_b_data;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr == SEL_B_DATA) |=> b_data_ff == $past(req.wdata);
  endproperty
  a_wr_b_data: assert property (p_wr_b_data) else $error("b latch write lost");

  property p_wr_c_data;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr == SEL_C_DATA) |=> c_data_ff == $past(req.wdata[C_BIT]);
  endproperty
  a_wr_c_data: assert property (p_wr_c_data) else $error("c latch write lost");

  property p_rd_in;
    @(posedge core_clk) disable iff (!rstn)
      (req.sel && req.addr == SEL_A_DATA && a_dir_ff == 8'hff) |-> rdata == pin_sync_lvl[7:0];
  endproperty
  a_rd_in: assert property (p_rd_in) else $error("input read not pin level");

  property p_rd_b_out;
    @(posedge core_clk) disable iff (!rstn)
      (req.sel && req.addr == SEL_B_DATA && b_dir_ff == 8'h00) |-> rdata == b_data_ff;
  endproperty
  a_rd_b_out: assert property (p_rd_b_out) else $error("b output read not latch");

  property p_rd_idle;
    @(posedge core_clk) disable iff (!rstn)
      !req.sel |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without select");

  property p_refused_rd;
    @(posedge core_clk) disable iff (!rstn)
      (req.sel && req.addr > SEL_C_WU) |-> rdata == 8'h00;
  endproperty
  a_refused_rd: assert property (p_refused_rd) else $error("unused select read nonzero");

  property p_refused_wr;
    @(posedge core_clk) disable iff (!rstn)
      (wr_en && !soft_rst && req.addr > SEL_C_WU) |=>
        $stable(all_data) && $stable(all_dir) && $stable(all_pu) && $stable(all_wu);
  endproperty
  a_refused_wr: assert property (p_refused_wr) else $error("unused select wrote");

  property p_cfg_hold;
    @(posedge core_clk) disable iff (!rstn)
      (!wr_en && !soft_rst) |=> $stable(all_dir) && $stable(all_pu) && $stable(all_wu);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved unwritten");

  property p_c_hold;
    @(posedge core_clk) disable iff (!rstn)
      (!wr_en && !soft_rst) |=> $stable(c_data_ff);
  endproperty
  a_c_hold: assert property (p_c_hold) else $error("c latch moved unwritten");

  property p_halt_keep_data;
    @(posedge core_clk) disable iff (!rstn)
      (wdt_timeout && sys.halted && !wr_en) |=> $stable(all_data) && $stable(all_wu);
  endproperty
  a_halt_keep_data: assert property (p_halt_keep_data) else $error("halted wdt moved data");

  property p_wake_cause;
    @(posedge core_clk) disable iff (!rstn)
      wake_req |-> |(wake_arm & ~pin_sync_lvl);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without low armed pin");

  property p_wake_unarmed;
    @(posedge core_clk) disable iff (!rstn)
      (wake_arm == '0) |-> !wake_req;
  endproperty
  a_wake_unarmed: assert property (p_wake_unarmed) else $error("wake with no pin armed");

  property p_power_on;
    @(posedge core_clk) disable iff (!rstn)
      $rose(rstn) |-> (&all_dir) && (&all_data) && (all_pu == '0) && (all_wu == '0);
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on values wrong");

  property p_sync_lag;
    @(posedge core_clk) disable iff (!rstn)
      $past(rstn, 2) |-> pin_sync_lvl == $past(pin_in, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("pin level not two edges old");
endmodule : gpio_ports

// File: testbench/pin_world.sv
/*
  external switches on the seventeen pins.
  assumes the bench says per pin whether a switch drives and to what level.
*/
`timescale 1ns/1ps
module pin_world (
  input wire logic core_clk,
  input wire logic [16:0] sw_drive,
  input wire logic [16:0] sw_level,
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  input wire logic [16:0] pin_pullup,
  output logic [16:0] pin_in
);
  // ==========================================================
  // wire level
  logic [16:0] float_ff = '0;
  // an undriven pin without pull-up wanders, so no read of it passes by luck
  always_ff @(posedge core_clk) begin
    float_ff <= ~pin_in;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw_drive & sw_level)
                | (~pin_oe & ~sw_drive & (pin_pullup | float_ff));
endmodule : pin_world

// File: testbench/testbench.sv
/*
  register and pin tests of the three-port i/o block.
  assumes the select map and reset values of gpio_pkg.
*/
`timescale 1ns/1ps
module testbench;
  import gpio_pkg::*;
  // ==========================================================
  // harness
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_t req = '0;
  logic wdt_timeout = 1'b0;
  sys_state_t sys = 2'h2;
  logic [16:0] sw_drive = '1;
  logic [16:0] sw_level = '1;
  logic [16:0] pin_in, pin_out, pin_oe, pin_pullup;
  logic [7:0] rdata;
  logic wake_req;
  int n_errors = 0;
  int n_tests = 0;
  int n_wake = 0;
  always #20 core_clk = ~core_clk;
  gpio_ports i_dut (.core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata),
    .wdt_timeout(wdt_timeout), .sys(sys), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .wake_req(wake_req));
  pin_world i_pins (.core_clk(core_clk), .sw_drive(sw_drive), .sw_level(sw_level),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_in(pin_in));
  // one-cycle pulse, so sample it mid-cycle
  always @(negedge core_clk) begin
    if (wake_req === 1'b1) begin
      n_wake++;
    end
  end
  // ==========================================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one idle cycle between accesses keeps drives apart
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req = '{1'b1, 1'b1, a, d};
    @(negedge core_clk);
    req.sel = 1'b0;
  endtask : wr
  task rd_check(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    @(negedge core_clk);
    req = '{1'b1, 1'b0, a, 8'h00};
    #10;
    d = rdata;
    check(d, exp);
    @(negedge core_clk);
    req.sel = 1'b0;
  endtask : rd_check
  task cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cycles
  task wdt_pulse;
    @(negedge core_clk);
    wdt_timeout = 1'b1;
    @(negedge core_clk);
    wdt_timeout = 1'b0;
  endtask : wdt_pulse
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  function automatic logic [7:0] rst_val(input logic [3:0] a);
    return a[1] ? RST_PU : (a[3] ? C_MASK : RST_DATA);
  endfunction : rst_val
  // ==========================================================
  // watchdog
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    check(pin_oe, 17'h0);
    check(pin_out, 17'h1ffff);
    for (int a = 0; a < 12; a++) begin
      rd_check(a[3:0], rst_val(a[3:0]));
    end
    for (int a = 0; a < 12; a++) begin
      if (a[1]) begin
        wr(a[3:0], 8'ha5);
        rd_check(a[3:0], a[3] ? 8'h01 : 8'ha5);
      end
    end
    check(pin_pullup, {1'h1, 8'ha5, 8'ha5});
    wr(4'hc, 8'hff);
    rd_check(4'hc, 8'h00);
    rd_check(SEL_A_PU, 8'ha5);
    // latch loaded while still an input
    wr(SEL_A_DATA, 8'h3c);
    check(pin_oe[7:0], 8'h00);
    wr(SEL_A_DIR, 8'h0f);
    check(pin_oe[7:0], 8'hf0);
    check(pin_out[7:0], 8'h3c);
    check(pin_pullup[7:0], 8'h05);
    sw_level[7:0] = 8'hc3;
    cycles(3);
    rd_check(SEL_A_DATA, 8'h33);
    sw_level[7:0] = 8'h0a;
    cycles(3);
    rd_check(SEL_A_DATA, 8'h3a);
    wr(SEL_A_PU, 8'h00);
    check(pin_out[7:0], 8'h3c);
    wr(SEL_B_DATA, 8'h96);
    wr(SEL_B_DIR, 8'h00);
    check(pin_out[15:8], 8'h96);
    rd_check(SEL_B_DATA, 8'h96);
    wr(SEL_C_DATA, 8'hfe);
    wr(SEL_C_DIR, 8'h00);
    check({pin_oe[16], pin_out[16]}, 2'h2);
    rd_check(SEL_C_DATA, 8'h00);
    // wake: only halted, enabled and input together
    sw_level = '1;
    wr(SEL_A_DATA, 8'hff);
    for (int k = 0; k < 4; k++) begin
      sys.halted = (k != 1);
      wr(SEL_A_WU, {7'h00, k != 2});
      wr(SEL_A_DIR, (k != 3) ? 8'hff : 8'hfe);
      sw_level[0] = 1'b1;
      cycles(4);
      n_wake = 0;
      sw_level[0] = 1'b0;
      cycles(8);
      check(n_wake, 32'(k == 0));
    end
    // switches let go: pulled inputs rise, output pin 0 drives, the rest wander
    sw_drive[7:0] = 8'h00;
    wr(SEL_A_PU, 8'h3c);
    check(pin_pullup[7:0], 8'h3c);
    check(pin_in[5:2], 4'hf);
    wdt_pulse();
    rd_check(SEL_A_PU, 8'h3c);
    rd_check(SEL_C_DIR, 8'h00);
    check(pin_pullup[7:0], 8'h3c);
    sys.halted = 1'h0;
    wdt_pulse();
    rd_check(SEL_A_PU, 8'h00);
    rd_check(SEL_A_WU, 8'h00);
    rd_check(SEL_C_DIR, 8'h01);
    check(pin_out, 17'h1ffff);
    check(pin_oe, 17'h0);
    check(pin_pullup, 17'h0);
    test_done();
  end
endmodule : testbench
